//--- lsfd_pkg.sv
package lsfd_pkg;

  // identifier layout
  localparam int KEY_W = 6;
  localparam int ID_W = 8;
  localparam int BIT_EVEN = 6;
  localparam int BIT_ODD = 7;
  localparam int BIT_LEN_HI = 5;
  localparam int BIT_LEN_LO = 4;
  localparam int TOP_BIT = 7;
  localparam int ADDR_W = 7;
  localparam int OTP_W = 4;
  localparam int HW_W = 3;

  // reserved identifiers
  localparam logic [5:0] ID_COMMAND = 6'h3c;
  localparam logic [5:0] ID_READ = 6'h3d;
  localparam logic [5:0] ID_EXTENDED = 6'h3f;

  // payload lengths
  localparam int MAX_BYTES = 8;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_MID = 4'h4;
  localparam logic [3:0] LEN_LONG = 4'h8;

  // special payload values
  localparam logic [7:0] MARKER_VAL = 8'h80;
  localparam logic [7:0] SLEEP_VAL = 8'h00;
  localparam logic [7:0] CSUM_INIT = 8'h00;

  // dynamic identifier table, indexed by pointer
  localparam int PTR_W = 4;
  localparam int NUM_PTR = 9;
  localparam logic [3:0] PTR_GP2 = 4'h0;
  localparam logic [3:0] PTR_GP4 = 4'h1;
  localparam logic [3:0] PTR_GET_POS = 4'h2;
  localparam logic [3:0] PTR_GET_STAT = 4'h3;
  localparam logic [3:0] PTR_PREPARE = 4'h8;

  // payload byte positions
  localparam int B_FIRST = 0;
  localparam int B_SECOND = 1;
  localparam int B_THIRD = 2;

  // frame classes
  typedef enum logic [2:0] {
    K_NONE,
    K_GP,
    K_APP_WR,
    K_DIR_RD,
    K_PREP,
    K_CMD,
    K_IND_RD
  } lsfd_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DATA,
    ST_CHECK
  } lsfd_state_e;

endpackage

//--- lsfd_id_if.sv
`timescale 1ns/1ps
interface lsfd_id_if;
  logic clk;
  logic rst;
  logic [lsfd_pkg::ID_W-1:0] id;
  logic [lsfd_pkg::NUM_PTR*lsfd_pkg::KEY_W-1:0] dyn;
  logic ok;
  lsfd_pkg::lsfd_kind_e kind;
  logic [3:0] len;
  logic [lsfd_pkg::PTR_W-1:0] ptr;

  modport checker_end (
    input clk, rst, id, dyn,
    output ok, kind, len, ptr
  );
  modport decoder_end (
    output clk, rst, id, dyn,
    input ok, kind, len, ptr
  );
endinterface

//--- lsfd_id_checker.sv
`timescale 1ns/1ps
module lsfd_id_checker (
  // identifier and its classification
  lsfd_id_if.checker_end cif
);

  logic [lsfd_pkg::KEY_W-1:0] key;
  logic even_bit;
  logic odd_bit;
  logic hit;
  logic [lsfd_pkg::PTR_W-1:0] hit_ptr;
  logic reserved;

  // first table entry whose identifier equals the key
  function automatic logic [lsfd_pkg::PTR_W:0] find_ptr(
    input logic [lsfd_pkg::KEY_W-1:0] k,
    input logic [lsfd_pkg::NUM_PTR*lsfd_pkg::KEY_W-1:0] tab
  );
    logic [lsfd_pkg::PTR_W:0] r;
    r = '0;
    for (int i = lsfd_pkg::NUM_PTR - 1; i >= 0; i--)
    begin
      if (tab[i*lsfd_pkg::KEY_W +: lsfd_pkg::KEY_W] == k)
      begin
        r = {1'b1, i[lsfd_pkg::PTR_W-1:0]};
      end
    end
    return r;
  endfunction

  // parity over the key
  // RULE_01 parity bit computation
  assign key = cif.id[lsfd_pkg::KEY_W-1:0];
  assign even_bit = key[0] ^ key[1] ^ key[2] ^ key[4];
  assign odd_bit = ~(key[1] ^ key[3] ^ key[4] ^ key[5]);
  // RULE_21 bad parity drops frame
  assign cif.ok = (cif.id[lsfd_pkg::BIT_EVEN] == even_bit) &&
                  (cif.id[lsfd_pkg::BIT_ODD] == odd_bit);

  // RULE_05 length from code bits
  assign cif.len = cif.id[lsfd_pkg::BIT_LEN_HI] ? (cif.id[lsfd_pkg::BIT_LEN_LO] ?
                   lsfd_pkg::LEN_LONG : lsfd_pkg::LEN_MID) : lsfd_pkg::LEN_SHORT;

  // RULE_20 reserved ids never dynamic
  assign reserved = (key == lsfd_pkg::ID_COMMAND) || (key == lsfd_pkg::ID_READ) ||
                    (key == lsfd_pkg::ID_EXTENDED);
  assign {hit, hit_ptr} = reserved ? '0 : find_ptr(key, cif.dyn);
  assign cif.ptr = hit_ptr;

  // classify the identifier
  always_comb
  begin
    cif.kind = lsfd_pkg::K_NONE;
    if (!cif.ok)
      cif.kind = lsfd_pkg::K_NONE;
    else if (key == lsfd_pkg::ID_COMMAND)
      cif.kind = lsfd_pkg::K_CMD;
    // RULE_14 0x3d read is indirect
    else if (key == lsfd_pkg::ID_READ)
      cif.kind = lsfd_pkg::K_IND_RD;
    else if (hit)
    begin
      if (hit_ptr == lsfd_pkg::PTR_GP2 || hit_ptr == lsfd_pkg::PTR_GP4)
        cif.kind = lsfd_pkg::K_GP;
      else if (hit_ptr == lsfd_pkg::PTR_GET_POS || hit_ptr == lsfd_pkg::PTR_GET_STAT)
        cif.kind = lsfd_pkg::K_DIR_RD;
      // RULE_16 prepare id has bit five clear
      else if (hit_ptr == lsfd_pkg::PTR_PREPARE)
        cif.kind = key[lsfd_pkg::BIT_LEN_HI] ? lsfd_pkg::K_NONE : lsfd_pkg::K_PREP;
      else
        cif.kind = lsfd_pkg::K_APP_WR;
    end
  end

  // RULE_01 parity check ties to key
  a_parity_match: assert property (@(posedge cif.clk) disable iff (cif.rst) // RULE_01
    cif.ok |-> (cif.id[6] == (cif.id[0] ^ cif.id[1] ^ cif.id[2] ^ cif.id[4])) &&
               (cif.id[7] == !(cif.id[1] ^ cif.id[3] ^ cif.id[4] ^ cif.id[5])))
    else $error("identifier accepted with wrong parity");

  a_extended_unused: assert property (@(posedge cif.clk) disable iff (cif.rst) // RULE_20
    (cif.id[5:0] == 6'h3f) |-> (cif.kind == lsfd_pkg::K_NONE))
    else $error("extended identifier classified as a frame");

  a_length_map: assert property (@(posedge cif.clk) disable iff (cif.rst) // RULE_05
    (cif.id[5:4] == 2'b11 && cif.len == 4'h8) || (cif.id[5:4] == 2'b10 && cif.len == 4'h4) ||
    (!cif.id[5] && cif.len == 4'h2))
    else $error("length code mapped wrongly");

endmodule

//--- lsfd_frame_decoder.sv
`timescale 1ns/1ps
// What this block does
// RULE_01 - identifier parity bits from key bits
// RULE_02 - command byte top bit set; zero is sleep
// RULE_03 - general frame: command, flag plus node number
// RULE_04 - flag clear all act; set needs address
// RULE_05 - length code gives 2, 4, 8 bytes
// RULE_06 - bound application write executes on every node
// RULE_07 - master gives each node its own id
// RULE_08 - 0x3c frame: marker, command, address, parameters
// RULE_09 - read frame: one slave sends data, checksum
// RULE_10 - direct read id only triggers a response
// RULE_11 - indirect read answered only right after prepare
// RULE_12 - every response carries own physical address
// RULE_13 - direct read answered with no prepare
// RULE_14 - 0x3d eight byte read is indirect
// RULE_15 - prepare carries address and command; addressee arms
// RULE_16 - short prepare: bit five clear, flagged bytes
// RULE_17 - 0x3c frame also arms indirect read
// RULE_18 - checksum inverted carry-around sum of data
// RULE_19 - address is four otp plus three pins
// RULE_20 - 0x3c and 0x3f never dynamic ids
// RULE_21 - bad parity frame ignored entirely; its header still clears prep_armed
module lsfd_frame_decoder #(
  parameter int MAXB = lsfd_pkg::MAX_BYTES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // frame bytes from the protocol handler
  input wire logic hdr_valid,
  input wire logic [lsfd_pkg::ID_W-1:0] hdr_id,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  // node address and identifier table
  input wire logic [lsfd_pkg::OTP_W-1:0] otp_addr,
  input wire logic [lsfd_pkg::HW_W-1:0] hw_addr_pin,
  input wire logic [lsfd_pkg::NUM_PTR*lsfd_pkg::KEY_W-1:0] dyn_table,
  // decoded command
  output logic cmd_valid,
  output lsfd_pkg::lsfd_kind_e cmd_kind,
  output logic [lsfd_pkg::PTR_W-1:0] cmd_ptr,
  output logic [6:0] cmd_code,
  output logic [3:0] cmd_len,
  output logic [MAXB*8-1:0] cmd_payload,
  output logic sleep_req,
  // read response request
  output logic resp_start,
  output logic resp_indirect,
  output logic [lsfd_pkg::PTR_W-1:0] resp_ptr,
  output logic [6:0] resp_code,
  output logic [3:0] resp_len,
  output logic [lsfd_pkg::ADDR_W-1:0] resp_addr,
  // status
  output logic prep_armed,
  output logic parity_err,
  output logic checksum_err
);

  lsfd_id_if idb();
  lsfd_pkg::lsfd_state_e state;
  lsfd_pkg::lsfd_state_e next_state;
  lsfd_pkg::lsfd_kind_e kind;
  logic [lsfd_pkg::PTR_W-1:0] ptr;
  logic [3:0] len;
  logic [3:0] cnt;
  logic [7:0] acc;
  logic [7:0] pay_mem [MAXB];
  logic [lsfd_pkg::HW_W-1:0] hw_meta;
  logic [lsfd_pkg::HW_W-1:0] hw_sync;
  logic [lsfd_pkg::ADDR_W-1:0] own_addr;
  logic [6:0] prep_code;
  logic hdr_take;
  logic byte_take;
  logic last_data;
  logic check_take;
  logic csum_good;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic gp_act;
  logic cmd3c_act;
  logic is_marker;
  logic do_cmd;
  logic do_sleep;
  logic do_arm;
  logic [6:0] next_code;
  logic dir_rd;
  logic ind_rd;
  logic [MAXB*8-1:0] packed_pay;

  // end-around carry accumulation
  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  // flagged node number equals own address
  function automatic logic addr_hit(input logic [7:0] v, input logic [6:0] own);
    return v[lsfd_pkg::ADDR_W-1:0] == own;
  endfunction

  // identifier classification
  assign idb.clk = clk;
  assign idb.rst = rst;
  assign idb.id = hdr_id;
  assign idb.dyn = dyn_table;

  lsfd_id_checker u_id (
    .cif(idb.checker_end)
  );

  // RULE_19 address from otp and pins
  assign own_addr = {otp_addr, hw_sync};

  // strobes
  assign hdr_take = ce && hdr_valid;
  assign byte_take = ce && data_valid && !hdr_valid;
  assign last_data = (state == lsfd_pkg::ST_DATA) && (cnt == len - 4'h1);
  assign check_take = byte_take && (state == lsfd_pkg::ST_CHECK);
  // RULE_18 inverted sum of data only
  assign csum_good = data_byte == ~acc;

  // payload fields
  assign b0 = pay_mem[lsfd_pkg::B_FIRST];
  assign b1 = pay_mem[lsfd_pkg::B_SECOND];
  assign b2 = pay_mem[lsfd_pkg::B_THIRD];
  assign is_marker = b0 == lsfd_pkg::MARKER_VAL;

  // RULE_03 command then flagged node
  // RULE_04 flag clear or address match
  assign gp_act = b0[lsfd_pkg::TOP_BIT] &&
                  (!b1[lsfd_pkg::TOP_BIT] || addr_hit(b1, own_addr));
  // RULE_08 marker, command, address
  assign cmd3c_act = is_marker && (!b2[lsfd_pkg::TOP_BIT] || addr_hit(b2, own_addr));

  // decisions at the checksum byte
  always_comb
  begin
    do_cmd = 1'b0;
    do_arm = 1'b0;
    do_sleep = 1'b0;
    next_code = b0[6:0];
    if (check_take && csum_good)
    begin
      unique case (kind)
        lsfd_pkg::K_GP:
        begin
          // RULE_02 low values are broadcast only
          do_sleep = b0 == lsfd_pkg::SLEEP_VAL;
          do_cmd = gp_act;
        end
        // RULE_06 bound command ignores address
        // RULE_07 node-bound id also lands here
        lsfd_pkg::K_APP_WR:
          do_cmd = 1'b1;
        lsfd_pkg::K_CMD:
        begin
          do_sleep = b0 == lsfd_pkg::SLEEP_VAL;
          do_cmd = cmd3c_act;
          next_code = b1[6:0];
          // RULE_17 long command frame prepares
          do_arm = is_marker && addr_hit(b2, own_addr);
        end
        // RULE_15 only addressee arms
        // RULE_16 both bytes flagged
        lsfd_pkg::K_PREP:
          do_arm = b0[lsfd_pkg::TOP_BIT] && b1[lsfd_pkg::TOP_BIT] && addr_hit(b1, own_addr);
        default:
          do_cmd = 1'b0;
      endcase
    end
  end

  // RULE_13 direct read needs no prepare
  assign dir_rd = idb.kind == lsfd_pkg::K_DIR_RD;
  // RULE_11 indirect read only after prepare
  assign ind_rd = (idb.kind == lsfd_pkg::K_IND_RD) && prep_armed;

  // frame sequencing
  always_comb
  begin
    next_state = state;
    if (hdr_take)
    begin
      // RULE_10 reads never collect a command
      // RULE_09 read data comes from the responder
      unique case (idb.kind)
        lsfd_pkg::K_GP, lsfd_pkg::K_APP_WR, lsfd_pkg::K_CMD, lsfd_pkg::K_PREP:
          next_state = lsfd_pkg::ST_DATA;
        default:
          next_state = lsfd_pkg::ST_IDLE;
      endcase
    end
    else if (byte_take && last_data)
      next_state = lsfd_pkg::ST_CHECK;
    else if (check_take)
      next_state = lsfd_pkg::ST_IDLE;
  end

  // payload as one word
  always_comb
  begin
    packed_pay = '0;
    for (int i = 0; i < MAXB; i++)
      packed_pay[i*8 +: 8] = pay_mem[i];
  end

  // pin synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hw_meta <= '0;
      hw_sync <= '0;
    end
    else if (ce)
    begin
      hw_meta <= hw_addr_pin;
      hw_sync <= hw_meta;
    end
  end

  // header capture and byte collection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= lsfd_pkg::ST_IDLE;
      kind <= lsfd_pkg::K_NONE;
      ptr <= '0;
      len <= lsfd_pkg::LEN_SHORT;
      cnt <= '0;
      acc <= lsfd_pkg::CSUM_INIT;
    end
    else if (ce)
    begin
      state <= next_state;
      if (hdr_take)
      begin
        kind <= idb.kind;
        ptr <= idb.ptr;
        len <= idb.len;
        cnt <= '0;
        acc <= lsfd_pkg::CSUM_INIT;
      end
      else if (byte_take && state == lsfd_pkg::ST_DATA)
      begin
        cnt <= cnt + 4'h1;
        acc <= csum_add(acc, data_byte);
      end
    end
  end

  // payload store
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < MAXB; i++)
        pay_mem[i] <= '0;
    end
    else if (ce && byte_take && state == lsfd_pkg::ST_DATA)
      pay_mem[cnt[2:0]] <= data_byte;
  end

  // prepare state, consumed by the very next header
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prep_armed <= 1'b0;
      prep_code <= '0;
    end
    else if (ce)
    begin
      if (hdr_take)
        prep_armed <= 1'b0;
      else if (do_arm)
      begin
        prep_armed <= 1'b1;
        prep_code <= next_code;
      end
    end
  end

  // command and status outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_valid <= 1'b0;
      cmd_kind <= lsfd_pkg::K_NONE;
      cmd_ptr <= '0;
      cmd_code <= '0;
      cmd_len <= '0;
      cmd_payload <= '0;
      sleep_req <= 1'b0;
      parity_err <= 1'b0;
      checksum_err <= 1'b0;
    end
    else if (ce)
    begin
      cmd_valid <= do_cmd;
      sleep_req <= do_sleep;
      parity_err <= hdr_take && !idb.ok;
      checksum_err <= check_take && !csum_good;
      if (do_cmd)
      begin
        cmd_kind <= kind;
        cmd_ptr <= ptr;
        cmd_code <= next_code;
        cmd_len <= len;
        cmd_payload <= packed_pay;
      end
    end
  end

  // response request outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resp_start <= 1'b0;
      resp_indirect <= 1'b0;
      resp_ptr <= '0;
      resp_code <= '0;
      resp_len <= '0;
      resp_addr <= '0;
    end
    else if (ce)
    begin
      // RULE_12 response carries own address
      resp_addr <= own_addr;
      // RULE_21 parity failure never answered
      resp_start <= hdr_take && (dir_rd || ind_rd);
      if (hdr_take && (dir_rd || ind_rd))
      begin
        resp_indirect <= ind_rd;
        resp_ptr <= idb.ptr;
        resp_code <= ind_rd ? prep_code : 7'h00;
        resp_len <= idb.len;
      end
    end
  end

  a_direct_answer: assert property (@(posedge clk) disable iff (rst) // RULE_13
    (ce && hdr_valid && idb.kind == lsfd_pkg::K_DIR_RD) |=> resp_start && !resp_indirect)
    else $error("direct read not answered");

  a_indirect_gated: assert property (@(posedge clk) disable iff (rst) // RULE_11
    (ce && hdr_valid && idb.kind == lsfd_pkg::K_IND_RD && !prep_armed) |=> !resp_start)
    else $error("indirect read answered without prepare");

  a_prepare_consumed: assert property (@(posedge clk) disable iff (rst) // RULE_11
    (ce && hdr_valid) |=> !prep_armed)
    else $error("prepare survived a following header");

  a_parity_silent: assert property (@(posedge clk) disable iff (rst) // RULE_21
    (ce && hdr_valid && !idb.ok) |=> parity_err && !resp_start && state == lsfd_pkg::ST_IDLE)
    else $error("bad parity frame not dropped");

  a_direct_read_only: assert property (@(posedge clk) disable iff (rst) // RULE_10
    (ce && hdr_valid && idb.kind == lsfd_pkg::K_DIR_RD) |=> state == lsfd_pkg::ST_IDLE)
    else $error("direct read identifier collected a command");

  a_resp_address: assert property (@(posedge clk) disable iff (rst) // RULE_12
    ($rose(resp_start) && $past(ce)) |-> resp_addr == $past(own_addr))
    else $error("response address is not the own address");

  a_gp_addressing: assert property (@(posedge clk) disable iff (rst) // RULE_04
    ($rose(cmd_valid) && cmd_kind == lsfd_pkg::K_GP && cmd_payload[15]) |->
      cmd_payload[14:8] == $past(own_addr))
    else $error("addressed command taken for another node");

  a_checksum_ok: assert property (@(posedge clk) disable iff (rst) // RULE_18
    $rose(cmd_valid) |-> $past(data_byte) == ~$past(acc))
    else $error("command taken with a bad checksum");

endmodule

//--- lsfd_master_model.sv
`timescale 1ns/1ps
module lsfd_master_model (
  // clock of the node
  input wire logic clk,
  // header and byte strobes toward the node
  output logic hdr_valid,
  output logic [7:0] hdr_id,
  output logic data_valid,
  output logic [7:0] data_byte
);
  // quiet lines at start
  initial
  begin
    hdr_valid = 1'b0;
    hdr_id = 8'h00;
    data_valid = 1'b0;
    data_byte = 8'h00;
  end

  function automatic logic [7:0] protect(input logic [5:0] k);
    protect = {~(k[1] ^ k[3] ^ k[4] ^ k[5]), k[0] ^ k[1] ^ k[2] ^ k[4], k};
  endfunction

  // header strobe; bad flips the odd parity bit
  task automatic header(input logic [5:0] k, input logic bad);
    @(negedge clk);
    hdr_id = protect(k) ^ {bad, 7'h00};
    hdr_valid = 1'b1;
    @(negedge clk);
    hdr_valid = 1'b0;
    hdr_id = ~hdr_id; // released line no longer shows the old value
  endtask

  // data bytes back to back, then inverted carry-around sum
  task automatic payload(input int n, input logic [63:0] b, input logic bad);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < n; i++)
    begin
      data_byte = b[8*i +: 8];
      data_valid = 1'b1;
      s = {1'b0, s[7:0]} + {1'b0, data_byte};
      s = {1'b0, s[7:0]} + {8'h00, s[8]};
      @(negedge clk);
    end
    data_byte = ~s[7:0] ^ {7'h00, bad};
    @(negedge clk);
    data_valid = 1'b0;
    data_byte = ~data_byte;
  endtask
endmodule

//--- lsfd_frame_decoder_tb.sv
`timescale 1ns/1ps
module lsfd_frame_decoder_tb;
  // clock, reset and node inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] otp_addr = 4'ha;
  logic [2:0] hw_addr_pin = 3'h5;
  logic [53:0] dyn_table;
  logic [6:0] own;
  // frame interface and results
  logic hdr_valid, data_valid, cmd_valid, sleep_req, resp_start, resp_indirect;
  logic prep_armed, parity_err, checksum_err;
  logic [7:0] hdr_id, data_byte;
  lsfd_pkg::lsfd_kind_e cmd_kind;
  logic [3:0] cmd_ptr, cmd_len, resp_ptr, resp_len;
  logic [6:0] cmd_code, resp_code, resp_addr;
  logic [63:0] cmd_payload;
  // bookkeeping
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] notes[$];
  // each pointer gets its own identifier
  logic [5:0] ids[9] = '{6'h10, 6'h21, 6'h12, 6'h33, 6'h24, 6'h05, 6'h36, 6'h17, 6'h08};

  // clock and identifier table
  always #2 clk = ~clk;
  always_comb
    for (int i = 0; i < 9; i++)
      dyn_table[6*i +: 6] = ids[i];
  assign own = {otp_addr, hw_addr_pin};

  lsfd_master_model u_master (.clk(clk), .hdr_valid(hdr_valid), .hdr_id(hdr_id),
    .data_valid(data_valid), .data_byte(data_byte));

  lsfd_frame_decoder u_dut (.clk(clk), .rst(rst), .ce(ce), .hdr_valid(hdr_valid),
    .hdr_id(hdr_id), .data_valid(data_valid), .data_byte(data_byte), .otp_addr(otp_addr),
    .hw_addr_pin(hw_addr_pin), .dyn_table(dyn_table), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ptr(cmd_ptr), .cmd_code(cmd_code), .cmd_len(cmd_len),
    .cmd_payload(cmd_payload), .sleep_req(sleep_req), .resp_start(resp_start),
    .resp_indirect(resp_indirect), .resp_ptr(resp_ptr), .resp_code(resp_code),
    .resp_len(resp_len), .resp_addr(resp_addr), .prep_armed(prep_armed),
    .parity_err(parity_err), .checksum_err(checksum_err));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // length code in key bits five and four
  function automatic logic [3:0] blen(input logic [5:0] k);
    blen = (k[5:4] == 2'b11) ? lsfd_pkg::LEN_LONG :
           (k[5:4] == 2'b10) ? lsfd_pkg::LEN_MID : lsfd_pkg::LEN_SHORT;
  endfunction

  // expected event words: flags cmd, resp, parity, checksum, sleep on top
  function automatic logic [31:0] want_cmd(input lsfd_pkg::lsfd_kind_e kd, input logic [3:0] p,
    input logic [6:0] c, input logic [3:0] n);
    want_cmd = {5'b10000, 9'h000, kd, p, c, n};
  endfunction
  function automatic logic [31:0] want_rsp(input logic ind, input logic [3:0] p,
    input logic [6:0] c, input logic [3:0] n);
    want_rsp = {5'b01000, 4'h0, ind, p, c, n, own};
  endfunction

  // event word from whatever the node reports this cycle
  function automatic logic [31:0] seen_word();
    seen_word = {cmd_valid, resp_start, parity_err, checksum_err, sleep_req, 27'h0};
    if (cmd_valid === 1'b1)
      seen_word[17:0] = {cmd_kind, cmd_ptr, cmd_code, cmd_len};
    else if (resp_start === 1'b1)
      seen_word[22:0] = {resp_indirect, resp_indirect ? 4'h0 : resp_ptr, resp_code,
        resp_len, resp_addr};
  endfunction

  // takes the oldest note whenever the node reports something
  always @(negedge clk)
    if (rst === 1'b0 && (cmd_valid | resp_start | parity_err | checksum_err | sleep_req) === 1'b1)
      check(seen_word(), notes.size() > 0 ? notes.pop_front() : 32'h0);

  // one frame: note, header, bytes, idle gap; bad[0] parity, bad[1] checksum
  task automatic frame(input logic [5:0] k, input int n, input logic [63:0] b,
    input logic [31:0] note, input logic [1:0] bad);
    if (note !== 32'h0)
      notes.push_back(note);
    u_master.header(k, bad[0]);
    // read frames carry no master bytes
    if (n > 0)
      u_master.payload(n, b, bad[1]);
    repeat (3) @(negedge clk);
  endtask

  // watchdog
  initial
  begin
    #40000;
    num_errors++;
    complete_run();
  end

  // main sequence
  initial
  begin
    logic [6:0] c;
    logic [63:0] r;
    void'($urandom(32'hd3b0));
    @(negedge clk);
    otp_addr = 4'($urandom());
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    c = 7'($urandom());
    r = {$urandom(), $urandom()};
    // flag clear, flag with own and foreign address
    frame(ids[0], 2, {48'h0, 8'h33, 1'b1, c}, want_cmd(lsfd_pkg::K_GP, 4'h0, c, 4'h2), 2'b00);
    frame(ids[1], 4, {32'h0, r[15:0], 1'b1, own, 1'b1, c},
      want_cmd(lsfd_pkg::K_GP, 4'h1, c, 4'h4), 2'b00);
    frame(ids[0], 2, {48'h0, 1'b1, own ^ 7'h01, 1'b1, c}, 32'h0, 2'b00);
    // sleep byte, then top bit clear without command
    frame(ids[0], 2, {48'h0, 8'h00, 8'h00}, 32'h0800_0000, 2'b00);
    frame(ids[0], 2, {48'h0, 8'h00, 8'h12}, 32'h0, 2'b00);
    frame(6'h3c, 8, {r[39:0], 24'h0}, 32'h0800_0000, 2'b00);
    // bound writes run whatever the address
    for (int i = 4; i < 8; i++)
    begin
      c = 7'($urandom());
      frame(ids[i], blen(ids[i]), {r[47:0], 1'b1, own ^ 7'h02, 1'b1, c},
        want_cmd(lsfd_pkg::K_APP_WR, 4'(i), c, blen(ids[i])), 2'b00);
    end
    frame(6'h3c, 8, {r[39:0], 1'b1, own, 1'b1, c, 8'h80},
      want_cmd(lsfd_pkg::K_CMD, 4'h0, c, 4'h8), 2'b00);
    check({31'h0, prep_armed}, 32'h1);
    check(cmd_payload[31:0], {r[7:0], 1'b1, own, 1'b1, c, 8'h80});
    check(cmd_payload[63:32], r[39:8]);
    frame(6'h3d, 0, 64'h0, want_rsp(1'b1, 4'h0, c, 4'h8), 2'b00);
    check({31'h0, prep_armed}, 32'h0);
    // indirect read with no prepare is ignored
    frame(6'h3d, 0, 64'h0, 32'h0, 2'b00);
    frame(ids[2], 0, 64'h0, want_rsp(1'b0, 4'h2, 7'h00, blen(ids[2])), 2'b00);
    frame(ids[3], 0, 64'h0, want_rsp(1'b0, 4'h3, 7'h00, blen(ids[3])), 2'b00);
    // clock enable low: a read header passes unseen
    ce = 1'b0;
    frame(ids[2], 0, 64'h0, 32'h0, 2'b00);
    ce = 1'b1;
    c = 7'($urandom());
    frame(ids[8], 2, {48'h0, 1'b1, own, 1'b1, c}, 32'h0, 2'b00);
    check({31'h0, prep_armed}, 32'h1);
    frame(6'h3d, 0, 64'h0, want_rsp(1'b1, 4'h0, c, 4'h8), 2'b00);
    // a frame between prepare and read breaks the pair
    frame(ids[8], 2, {48'h0, 1'b1, own, 1'b1, c}, 32'h0, 2'b00);
    frame(ids[0], 2, {48'h0, 1'b1, own ^ 7'h04, 1'b1, c}, 32'h0, 2'b00);
    check({31'h0, prep_armed}, 32'h0);
    frame(6'h3d, 0, 64'h0, 32'h0, 2'b00);
    // prepare for another node does not arm
    frame(ids[8], 2, {48'h0, 1'b1, own ^ 7'h08, 1'b1, c}, 32'h0, 2'b00);
    check({31'h0, prep_armed}, 32'h0);
    // bad parity, bad checksum, extended id
    frame(ids[0], 2, {48'h0, 8'h00, 1'b1, c}, 32'h2000_0000, 2'b01);
    frame(ids[0], 2, {48'h0, 8'h00, 1'b1, c}, 32'h1000_0000, 2'b10);
    frame(6'h3f, 8, r, 32'h0, 2'b00);
    check(32'(notes.size()), 32'h0);
    complete_run();
  end
endmodule
